// ===== include/fmrx_pkg.sv
package fmrx_pkg;

  // ***********************
  // bus and framing
  // ***********************
  localparam logic [6:0] DEV_ADDR   = 7'h10;
  localparam logic [3:0] BYTE_BITS  = 4'h8;
  localparam int         SYS_CLK_HZ = 40_000_000;
  localparam int         BUS_MAX_HZ = 400_000;
  // sys clocks per bus bit at top speed, sets the oversampling margin
  localparam int         BIT_CYCLES = SYS_CLK_HZ / BUS_MAX_HZ;

  // ***********************
  // register map
  // ***********************
  localparam int         REG_DEPTH = 32;
  localparam logic [7:0] IDX_CTRL  = 8'h00;
  localparam logic [7:0] IDX_RSSI  = 8'h03;
  localparam logic [7:0] IDX_STAT  = 8'h04;
  localparam logic [7:0] IDX_VOL   = 8'h14;
  localparam logic [7:0] IDX_DIVL  = 8'h15;
  localparam logic [7:0] IDX_MIX   = 8'h16;
  localparam logic [7:0] IDX_SYNH  = 8'h17;
  localparam int         CTRL_SRST = 7;
  localparam int         CTRL_STBY = 5;
  localparam int         CTRL_RXRQ = 4;
  localparam int         VOL_MUTE  = 7;
  localparam int         STAT_STEREO = 0;

  // ***********************
  // reset values
  // ***********************
  localparam logic [7:0]  DEF_CTRL  = 8'h20;
  localparam logic [7:0]  DEF_DIVL  = 8'h01;
  localparam logic [7:0]  DEF_MIX   = 8'h08;
  localparam logic [7:0]  DEF_SYNH  = 8'h5c;
  localparam logic [7:0]  DEF_OTHER = 8'h00;
  localparam logic [10:0] DEF_DIV   = 11'h001;
  localparam logic [12:0] DEF_SYNTH = 13'hb81;

  typedef enum logic [1:0] {
    MODE_IDLE = 2'h0,
    MODE_RX   = 2'h1,
    MODE_STBY = 2'h3
  } fmrx_mode_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_RX   = 3'h1,
    ST_RACK = 3'h3,
    ST_TX   = 3'h2,
    ST_TACK = 3'h6
  } fmrx_state_t;

  typedef enum logic [1:0] {
    PH_ADDR  = 2'h0,
    PH_INDEX = 2'h1,
    PH_DATA  = 2'h3
  } fmrx_phase_t;

  typedef struct packed {
    fmrx_mode_t  mode;
    logic        audio_mute;
    logic [10:0] ref_div;
    logic [12:0] synth_offset_word;
  } fmrx_cfg_t;

  localparam fmrx_cfg_t CFG_RESET = '{MODE_STBY, 1'b0, DEF_DIV, DEF_SYNTH};

endpackage

// ===== logic/fmrx_serial_ctrl.sv
`timescale 1ns/1ps
// Overview of operation
// [R1] bus runs at most 400 kHz
// [R2] eight bits MSB first, then acknowledge
// [R3] master stops or restarts after a nack
// [R4] early stop leaves unwritten registers unchanged
// [R5] partial byte discarded, never written
// [R6] start condition resets byte framing
// [R7] respond only to address 0010000
// [R8] address LSB selects write or read
// [R9] second byte is start index, auto-increment
// [R10] unlimited bytes until stop
// [R11] stop is SDA rising while SCL high
// [R12] master nack ends read, release SDA
// [R13] power-on loads all register defaults
// [R14] control bit 7 resets to standby
// [R15] after reset stay in standby
// [R16] receive when request set, standby clear
// [R17] 11-bit reference divider, default 0x01
// [R18] 13-bit synth offset word, default 0xB81
// [R19] reference clock divided by divider setting
// [R20] volume bit 7 mutes audio
// [R21] stereo indicator readable in status bit 0
// [R22] signal strength readable as 8-bit value
// [R23] standby outranks receive; both zero idle
module fmrx_serial_ctrl #(
  parameter int REG_DEPTH = fmrx_pkg::REG_DEPTH
) (
  input  wire logic               i_clk_sys,
  input  wire logic               i_sys_rst,
  input  wire logic               i_scl,
  input  wire logic               i_sda,
  output logic                    o_sda_o,
  output logic                    o_sda_oe_n,
  input  wire logic               i_ref_clk,
  input  wire logic [7:0]         i_signal_strength_db,
  input  wire logic               i_stereo_indicator,
  output fmrx_pkg::fmrx_cfg_t     o_cfg,
  output logic                    o_ref_tick
);

  localparam int AW = $clog2(REG_DEPTH);

  // ***********************
  // declarations
  // ***********************
  fmrx_pkg::fmrx_state_t state_r, state_nxt;
  fmrx_pkg::fmrx_phase_t phase_r, phase_nxt;
  fmrx_pkg::fmrx_cfg_t   cfg_nxt;
  logic [3:0]  bitcnt_r, bitcnt_nxt;
  logic [7:0]  shift_r, shift_nxt;
  logic [7:0]  idx_r, idx_nxt;
  logic        rw_r, rw_nxt;
  logic        nack_r, nack_nxt;
  logic        oe_n_r, oe_n_nxt;
  logic        scl_r, sda_r, ref_r;
  logic        wr_en;
  logic [7:0]  tx_byte;
  logic [7:0]  regs_r [REG_DEPTH];
  logic [10:0] rcnt_r, rcnt_nxt;
  logic        tick_nxt;
  logic        scl_rise, scl_fall, start_det, stop_det, ref_rise;

  // ***********************
  // helpers
  // ***********************
  // power-on and soft-reset contents of one register
  function automatic logic [7:0] reg_default(input logic [7:0] idx);
    if (idx == fmrx_pkg::IDX_CTRL)
      return fmrx_pkg::DEF_CTRL;
    else if (idx == fmrx_pkg::IDX_DIVL)
      return fmrx_pkg::DEF_DIVL;
    else if (idx == fmrx_pkg::IDX_MIX)
      return fmrx_pkg::DEF_MIX;
    else if (idx == fmrx_pkg::IDX_SYNH)
      return fmrx_pkg::DEF_SYNH;
    else
      return fmrx_pkg::DEF_OTHER;
  endfunction

  // byte seen by the master on a read; status comes live from the inputs
  function automatic logic [7:0] rd_byte(input logic [7:0] idx);
    // [R21] stereo status bit
    if (idx == fmrx_pkg::IDX_STAT)
      return {regs_r[idx[AW-1:0]][7:1], i_stereo_indicator};
    // [R22] signal strength read
    else if (idx == fmrx_pkg::IDX_RSSI)
      return i_signal_strength_db;
    else if (idx < 8'(REG_DEPTH))
      return regs_r[idx[AW-1:0]];
    else
      return 8'h00;
  endfunction

  // ***********************
  // bus line events
  // ***********************
  // lines are sampled every sys clock; at 40 MHz a 400 kHz bit spans
  // about BIT_CYCLES samples, so no edge can slip between two samples
  // [R1] oversampled bus edges
  assign scl_rise  = i_scl & ~scl_r;
  assign scl_fall  = ~i_scl & scl_r;
  // [R6] start detect
  assign start_det = i_scl & scl_r & sda_r & ~i_sda;
  // [R11] stop detect
  assign stop_det  = i_scl & scl_r & ~sda_r & i_sda;
  assign ref_rise  = i_ref_clk & ~ref_r;

  // a process rather than an assign, so stored bits and live status are tracked
  always_comb
    tx_byte = rd_byte(idx_r);

  // ***********************
  // target state machine
  // ***********************
  // next values of the bus target
  always_comb
  begin
    state_nxt  = state_r;
    phase_nxt  = phase_r;
    bitcnt_nxt = bitcnt_r;
    shift_nxt  = shift_r;
    idx_nxt    = idx_r;
    rw_nxt     = rw_r;
    nack_nxt   = nack_r;
    oe_n_nxt   = oe_n_r;
    wr_en      = 1'b0;
    // [R4] stop ends the transfer, nothing further written
    if (stop_det)
    begin
      state_nxt = fmrx_pkg::ST_IDLE;
      oe_n_nxt  = 1'b1;
    end
    // [R6] start resets framing, also as repeated start
    else if (start_det)
    begin
      state_nxt  = fmrx_pkg::ST_RX;
      phase_nxt  = fmrx_pkg::PH_ADDR;
      bitcnt_nxt = 4'h0;
      oe_n_nxt   = 1'b1;
    end
    else
    begin
      case (state_r)
        fmrx_pkg::ST_RX:
        begin
          // [R2] shift MSB first
          if (scl_rise && bitcnt_r != fmrx_pkg::BYTE_BITS)
          begin
            shift_nxt  = {shift_r[6:0], i_sda};
            bitcnt_nxt = bitcnt_r + 4'h1;
          end
          // [R5] act only on a whole byte
          else if (scl_fall && bitcnt_r == fmrx_pkg::BYTE_BITS)
          begin
            state_nxt = fmrx_pkg::ST_RACK;
            oe_n_nxt  = 1'b0;
            case (phase_r)
              fmrx_pkg::PH_ADDR:
              begin
                // [R7] address match
                if (shift_r[7:1] == fmrx_pkg::DEV_ADDR)
                begin
                  // [R8] direction bit
                  rw_nxt    = shift_r[0];
                  phase_nxt = fmrx_pkg::PH_INDEX;
                end
                else
                begin
                  state_nxt = fmrx_pkg::ST_IDLE;
                  oe_n_nxt  = 1'b1;
                end
              end
              fmrx_pkg::PH_INDEX:
              begin
                // [R9] start index
                idx_nxt   = shift_r;
                phase_nxt = fmrx_pkg::PH_DATA;
              end
              default:
              begin
                // [R10] write and advance, no limit
                wr_en   = 1'b1;
                idx_nxt = idx_r + 8'h01;
              end
            endcase
          end
        end
        fmrx_pkg::ST_RACK:
        begin
          // acknowledge held over one full clock pulse
          if (scl_fall)
          begin
            bitcnt_nxt = 4'h0;
            if (rw_r && phase_r == fmrx_pkg::PH_INDEX)
            begin
              state_nxt = fmrx_pkg::ST_TX;
              shift_nxt = tx_byte;
              oe_n_nxt  = tx_byte[7];
              idx_nxt   = idx_r + 8'h01;
            end
            else
            begin
              state_nxt = fmrx_pkg::ST_RX;
              oe_n_nxt  = 1'b1;
            end
          end
        end
        fmrx_pkg::ST_TX:
        begin
          // [R2] send MSB first, release for master ack
          if (scl_fall)
          begin
            if (bitcnt_r == fmrx_pkg::BYTE_BITS - 4'h1)
            begin
              state_nxt = fmrx_pkg::ST_TACK;
              oe_n_nxt  = 1'b1;
            end
            else
            begin
              shift_nxt  = {shift_r[6:0], 1'b0};
              oe_n_nxt   = shift_r[6];
              bitcnt_nxt = bitcnt_r + 4'h1;
            end
          end
        end
        fmrx_pkg::ST_TACK:
        begin
          if (scl_rise)
            nack_nxt = i_sda;
          else if (scl_fall)
          begin
            bitcnt_nxt = 4'h0;
            // [R12] nack leaves SDA released
            if (nack_r)
              state_nxt = fmrx_pkg::ST_IDLE;
            else
            begin
              state_nxt = fmrx_pkg::ST_TX;
              shift_nxt = tx_byte;
              oe_n_nxt  = tx_byte[7];
              idx_nxt   = idx_r + 8'h01;
            end
          end
        end
        default:
          oe_n_nxt = 1'b1;
      endcase
    end
  end

  // registers of the bus target
  always_ff @(posedge i_clk_sys or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      state_r  <= fmrx_pkg::ST_IDLE;
      phase_r  <= fmrx_pkg::PH_ADDR;
      bitcnt_r <= 4'h0;
      shift_r  <= 8'h00;
      idx_r    <= 8'h00;
      rw_r     <= 1'b0;
      nack_r   <= 1'b0;
      oe_n_r   <= 1'b1;
      scl_r    <= 1'b1;
      sda_r    <= 1'b1;
    end
    else
    begin
      state_r  <= state_nxt;
      phase_r  <= phase_nxt;
      bitcnt_r <= bitcnt_nxt;
      shift_r  <= shift_nxt;
      idx_r    <= idx_nxt;
      rw_r     <= rw_nxt;
      nack_r   <= nack_nxt;
      oe_n_r   <= oe_n_nxt;
      scl_r    <= i_scl;
      sda_r    <= i_sda;
    end
  end

  // ***********************
  // register file
  // ***********************
  // writes past the array are dropped; the soft reset bit is never
  // stored, so it reads back zero and needs no clearing
  always_ff @(posedge i_clk_sys or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      // [R13] power-on defaults
      for (int i = 0; i < REG_DEPTH; i++)
        regs_r[i] <= reg_default(8'(i));
    end
    // [R14] soft reset reloads defaults, standby included
    else if (wr_en && idx_r == fmrx_pkg::IDX_CTRL && shift_r[fmrx_pkg::CTRL_SRST])
    begin
      for (int i = 0; i < REG_DEPTH; i++)
        regs_r[i] <= reg_default(8'(i));
    end
    else if (wr_en && idx_r < 8'(REG_DEPTH))
      regs_r[idx_r[AW-1:0]] <= shift_r;
  end

  // ***********************
  // configuration outputs
  // ***********************
  // decoded configuration, registered once more for clean outputs
  always_comb
  begin
    // [R23] standby first, idle when both clear
    if (regs_r[fmrx_pkg::IDX_CTRL[AW-1:0]][fmrx_pkg::CTRL_STBY])
      cfg_nxt.mode = fmrx_pkg::MODE_STBY;
    // [R16] receive request
    else if (regs_r[fmrx_pkg::IDX_CTRL[AW-1:0]][fmrx_pkg::CTRL_RXRQ])
      cfg_nxt.mode = fmrx_pkg::MODE_RX;
    else
      cfg_nxt.mode = fmrx_pkg::MODE_IDLE;
    // [R20] mute
    cfg_nxt.audio_mute = regs_r[fmrx_pkg::IDX_VOL[AW-1:0]][fmrx_pkg::VOL_MUTE];
    // [R17] divider across two registers
    cfg_nxt.ref_div = {regs_r[fmrx_pkg::IDX_MIX[AW-1:0]][2:0],
                       regs_r[fmrx_pkg::IDX_DIVL[AW-1:0]]};
    // [R18] synth offset word, high byte then upper bits of mix
    cfg_nxt.synth_offset_word = {regs_r[fmrx_pkg::IDX_SYNH[AW-1:0]],
                                 regs_r[fmrx_pkg::IDX_MIX[AW-1:0]][7:3]};
  end

  // ***********************
  // reference divider
  // ***********************
  // reference is sampled, so it must stay below half of the sys clock;
  // a divider of zero is treated as one
  always_comb
  begin
    rcnt_nxt = rcnt_r;
    tick_nxt = 1'b0;
    // [R19] count reference edges
    if (ref_rise)
    begin
      if (rcnt_r + 11'h001 >= o_cfg.ref_div)
      begin
        rcnt_nxt = 11'h000;
        tick_nxt = 1'b1;
      end
      else
        rcnt_nxt = rcnt_r + 11'h001;
    end
  end

  // output and divider registers
  always_ff @(posedge i_clk_sys or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      // [R15] standby straight out of reset
      o_cfg      <= fmrx_pkg::CFG_RESET;
      o_ref_tick <= 1'b0;
      rcnt_r     <= 11'h000;
      ref_r      <= 1'b1;    // a rise needs a low sample first: no false edge
      o_sda_o    <= 1'b0;
      o_sda_oe_n <= 1'b1;
    end
    else
    begin
      o_cfg      <= cfg_nxt;
      o_ref_tick <= tick_nxt;
      rcnt_r     <= rcnt_nxt;
      ref_r      <= i_ref_clk;
      o_sda_o    <= 1'b0;    // open drain: only ever pulls low
      o_sda_oe_n <= oe_n_nxt;
    end
  end

endmodule

// ===== bench/fmrx_serial_ctrl_assertions.sv
`timescale 1ns/1ps
module fmrx_serial_ctrl_assertions #(
  parameter int REG_DEPTH = 32
) (
  input wire logic                i_clk_sys,
  input wire logic                i_sys_rst,
  input wire logic                i_scl,
  input wire logic                i_sda,
  input wire logic                o_sda_o,
  input wire logic                o_sda_oe_n,
  input wire logic                i_ref_clk,
  input wire logic [7:0]          i_signal_strength_db,
  input wire logic                i_stereo_indicator,
  input wire fmrx_pkg::fmrx_cfg_t o_cfg,
  input wire logic                o_ref_tick
);
  logic       scl_r;
  logic       sda_r;
  logic [7:0] sh_r;
  logic [7:0] sh_nxt;
  logic [3:0] cnt_r;
  logic [3:0] cnt_nxt;
  logic       first_r;
  logic       first_nxt;
  logic       start;
  logic       stop;
  logic       addr_end;
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (i_sys_rst);
  // ********************
  // bus tracker
  // ********************
  // events judged from previous and current samples, as the target sees them
  assign start    = i_scl && scl_r && !i_sda && sda_r;
  assign stop     = i_scl && scl_r && i_sda && !sda_r;
  assign addr_end = !i_scl && scl_r && first_r && (cnt_r == 4'h8);
  // bit count restarts at each start; first_r marks the address byte
  always_comb
  begin
    sh_nxt    = sh_r;
    cnt_nxt   = cnt_r;
    first_nxt = first_r;
    if (start)
    begin
      cnt_nxt   = 4'h0;
      first_nxt = 1'b1;
    end
    else if (i_scl && !scl_r)
    begin
      sh_nxt    = {sh_r[6:0], i_sda};
      cnt_nxt   = (cnt_r == 4'h8) ? 4'h0 : cnt_r + 4'h1;
      first_nxt = first_r && (cnt_r != 4'h8);
    end
  end
  // idle bus reads high, so no false start right after reset
  always_ff @(posedge i_clk_sys or posedge i_sys_rst)
    if (i_sys_rst)
      {scl_r, sda_r, sh_r, cnt_r, first_r} <= {1'b1, 1'b1, 8'h00, 4'h0, 1'b0};
    else
      {scl_r, sda_r, sh_r, cnt_r, first_r} <= {i_scl, i_sda, sh_nxt, cnt_nxt, first_nxt};
  // ********************
  // properties
  // ********************
  sda_low_only_a: assert property (o_sda_o == 1'b0)
    else $error("data output not held low");
  drive_on_low_a: assert property ($fell(o_sda_oe_n) |-> !$past(i_scl))
    else $error("data drive began with clock high");
  reset_defaults_a: assert property ($fell(i_sys_rst) |-> o_cfg == fmrx_pkg::CFG_RESET)
    else $error("configuration not at defaults after reset");
  cfg_on_low_a: assert property ($changed(o_cfg) |-> !i_scl && !$past(i_scl))
    else $error("configuration changed outside a byte end");
  stop_release_a: assert property (stop |-> ##2 o_sda_oe_n [*8])
    else $error("data line held after stop");
  addr_ack_a: assert property (addr_end && sh_r[7:1] == fmrx_pkg::DEV_ADDR
    |-> ##[1:2] !o_sda_oe_n ##1 !o_sda_oe_n [*8]) else $error("own address not acked");
  addr_nack_a: assert property (addr_end && sh_r[7:1] != fmrx_pkg::DEV_ADDR
    |-> ##1 o_sda_oe_n [*4]) else $error("foreign address acked");
  tick_single_a: assert property (o_ref_tick
    |-> $past(i_ref_clk) && !$past(i_ref_clk, 2) ##1 !o_ref_tick)
    else $error("reference tick not a single cycle after a reference rise");
  mode_legal_a: assert property (o_cfg.mode != 2'h2)
    else $error("undefined mode code");
endmodule

bind fmrx_serial_ctrl fmrx_serial_ctrl_assertions #(.REG_DEPTH(REG_DEPTH)) i_chk (
  .i_clk_sys(i_clk_sys), .i_sys_rst(i_sys_rst), .i_scl(i_scl), .i_sda(i_sda),
  .o_sda_o(o_sda_o), .o_sda_oe_n(o_sda_oe_n), .i_ref_clk(i_ref_clk),
  .i_signal_strength_db(i_signal_strength_db), .i_stereo_indicator(i_stereo_indicator),
  .o_cfg(o_cfg), .o_ref_tick(o_ref_tick));

// ===== bench/fmrx_i2c_master.sv
`timescale 1ns/1ps
module fmrx_i2c_master #(
  parameter int HALF = 50
) (
  input  wire logic i_clk,
  input  wire logic i_sda,
  output logic      o_scl,
  output logic      o_sda
);
  // bus idles high through reset so the target sees no false start
  initial
  begin
    o_scl = 1'b1;
    o_sda = 1'b1;
  end
  task automatic wt(input int n);
    repeat (n) @(posedge i_clk);
  endtask
  // bit period just under 400 kHz, data moves only with clock low
  task automatic bitx(input logic b, output logic r);
    o_sda <= b;
    wt(HALF);
    o_scl <= 1'b1;
    wt(HALF / 2);
    r = i_sda;
    wt(HALF / 2);
    o_scl <= 1'b0;
    wt(2);
  endtask
  // start or repeated start: data falls with clock high
  task automatic start;
    o_sda <= 1'b1;
    wt(HALF);
    o_scl <= 1'b1;
    wt(HALF);
    o_sda <= 1'b0;
    wt(HALF);
    o_scl <= 1'b0;
    wt(2);
  endtask
  // stop: data rises with clock high
  task automatic stop;
    o_sda <= 1'b0;
    wt(HALF);
    o_scl <= 1'b1;
    wt(HALF);
    o_sda <= 1'b1;
    wt(HALF);
  endtask
  // eight bits msb first, then the ack slot released
  task automatic wbyte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bitx(d[i], r);
    bitx(1'b1, r);
    ack = !r;
  endtask
  // ack withheld after the last byte wanted
  task automatic rbyte(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--)
    begin
      bitx(1'b1, r);
      d[i] = r;
    end
    bitx(last, r);
  endtask
endmodule

// ===== bench/tb.sv
`timescale 1ns/1ps
module tb;
  logic                clk;
  logic                rst;
  logic                ref_clk;
  logic [7:0]          rssi;
  logic                stereo;
  logic                scl;
  logic                m_sda;
  logic                sda;
  logic                sda_o;
  logic                sda_oe_n;
  logic                tick;
  fmrx_pkg::fmrx_cfg_t cfg;
  int                  failures = 0;
  int                  samples_checked = 0;
  int                  cyc = 0;
  // open-drain wire with pull-up: low if either side pulls
  assign sda = m_sda & (sda_oe_n | sda_o);
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  fmrx_serial_ctrl i_dut (.i_clk_sys(clk), .i_sys_rst(rst), .i_scl(scl), .i_sda(sda),
    .o_sda_o(sda_o), .o_sda_oe_n(sda_oe_n), .i_ref_clk(ref_clk),
    .i_signal_strength_db(rssi), .i_stereo_indicator(stereo), .o_cfg(cfg), .o_ref_tick(tick));
  fmrx_i2c_master i_mst (.i_clk(clk), .i_sda(sda), .o_scl(scl), .o_sda(m_sda));
  // reference clock at an eighth of the system clock; hang guard
  always @(posedge clk)
  begin
    cyc     <= cyc + 1;
    ref_clk <= cyc[2];
    if (cyc == 95000)
    begin
      failures++;
      close_out;
    end
  end
  // ********************
  // checks and bus cycles
  // ********************
  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp, input string what);
    samples_checked++;
    if (got !== exp)
    begin
      failures++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic chk_cfg(input fmrx_pkg::fmrx_cfg_t got, input fmrx_pkg::fmrx_cfg_t exp);
    samples_checked++;
    if (got !== exp)
    begin
      failures++;
      $display("wrong value at %0t: config got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] b [$]);
    logic ack;
    i_mst.start();
    foreach (b[i])
    begin
      i_mst.wbyte(b[i], ack);
      chk_byte({7'h00, ack}, 8'h01, "write ack");
    end
    i_mst.stop();
  endtask
  // index set by a write, then repeated start and read from there
  task automatic rd(input logic [7:0] idx, input logic [7:0] e [$]);
    logic       ack;
    logic [7:0] d;
    i_mst.start();
    i_mst.wbyte(8'h20, ack);
    chk_byte({7'h00, ack}, 8'h01, "write ack");
    i_mst.wbyte(idx, ack);
    chk_byte({7'h00, ack}, 8'h01, "index ack");
    i_mst.start();
    i_mst.wbyte(8'h21, ack);
    chk_byte({7'h00, ack}, 8'h01, "read ack");
    foreach (e[i])
    begin
      i_mst.rbyte(i == e.size() - 1, d);
      chk_byte(d, e[i], "read data");
    end
    i_mst.stop();
  endtask
  // ********************
  // scenarios
  // ********************
  task automatic t_reset;
    chk_cfg(cfg, fmrx_pkg::CFG_RESET);
    rd(8'h15, '{8'h01, 8'h08, 8'h5c});
    $display("test reset done");
  endtask
  task automatic t_modes;
    logic [7:0] ctl [4];
    logic [7:0] md [4];
    ctl = '{8'h10, 8'h00, 8'h30, 8'h20};
    md  = '{8'h01, 8'h00, 8'h03, 8'h03};
    for (int i = 0; i < 4; i++)
    begin
      wr('{8'h20, 8'h00, ctl[i]});
      chk_byte({6'h00, cfg.mode}, md[i], "mode");
    end
    wr('{8'h20, 8'h14, 8'h80});
    chk_byte({7'h00, cfg.audio_mute}, 8'h01, "mute");
    $display("test modes done");
  endtask
  task automatic t_burst;
    wr('{8'h20, 8'h15, 8'h03, 8'h0a, 8'h7f});
    chk_cfg(cfg, '{fmrx_pkg::MODE_STBY, 1'b1, 11'h203, 13'h0fe1});
    rd(8'h15, '{8'h03, 8'h0a, 8'h7f});
    wr('{8'h20, 8'h16, 8'h00});
    $display("test burst done");
  endtask
  // ticks over 24 reference edges, set divider decides how many
  task automatic t_tick(input logic [7:0] exp);
    logic [7:0] k;
    k = 8'h00;
    repeat (40) @(posedge clk);
    repeat (192)
    begin
      @(posedge clk);
      if (tick === 1'b1)
        k++;
    end
    chk_byte(k, exp, "tick count");
    $display("test tick done");
  endtask
  task automatic t_cut;
    logic ack;
    logic r;
    i_mst.start();
    i_mst.wbyte(8'h22, ack);
    i_mst.stop();
    chk_byte({7'h00, ack}, 8'h00, "foreign ack");
    i_mst.start();
    i_mst.wbyte(8'h20, ack);
    i_mst.wbyte(8'h14, ack);
    repeat (4) i_mst.bitx(1'b0, r);
    i_mst.stop();
    chk_byte({7'h00, cfg.audio_mute}, 8'h01, "mute kept");
    wr('{8'h20, 8'h15, 8'h05});
    rd(8'h15, '{8'h05, 8'h00, 8'h7f});
    $display("test cut done");
  endtask
  task automatic t_status;
    @(posedge clk);
    rssi   <= 8'ha5;
    stereo <= 1'b1;
    rd(8'h03, '{8'ha5, 8'h01});
    $display("test status done");
  endtask
  task automatic t_srst;
    wr('{8'h20, 8'h00, 8'h80});
    chk_cfg(cfg, fmrx_pkg::CFG_RESET);
    rd(8'h14, '{8'h00, 8'h01, 8'h08});
    $display("test soft reset done");
  endtask
  task automatic close_out;
    $display("comparisons %0d, mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  initial
  begin
    rst    = 1'b1;
    rssi   = 8'h00;
    stereo = 1'b0;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    repeat (4) @(posedge clk);
    t_reset;
    t_modes;
    t_burst;
    t_tick(8'h08);
    t_cut;
    t_status;
    t_srst;
    t_tick(8'h18);
    close_out;
  end
endmodule
